// ===== src/fdcr_defines.vh
`ifndef FDCR_DEFINES_VH
`define FDCR_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define FDCR_CLK_MHZ 100
`define FDCR_STEP_UNIT_US 500
`define FDCR_STEP_UNIT_CYC (`FDCR_STEP_UNIT_US * `FDCR_CLK_MHZ)

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define FDCR_MT_BIT 7
`define FDCR_DD_BIT 6
`define FDCR_SK_BIT 5
`define FDCR_OP_MSB 4
`define FDCR_OP_READ 5'h06
`define FDCR_OP_READ_DEL 5'h0C
`define FDCR_HEAD_BIT 2
`define FDCR_DS_HI_BIT 1
`define FDCR_DS_LO_BIT 0
`define FDCR_CMD_LAST 4'h8
`define FDCR_RES_LAST 3'h6

// ----------------------------------------
// sector size
// ----------------------------------------
`define FDCR_BASE_LEN 16'h0080
`define FDCR_MAX_SIZE_CODE 8'h07

// ----------------------------------------
// status bits and completion codes
// ----------------------------------------
`define FDCR_IC_NORMAL 2'h0
`define FDCR_IC_ABNORMAL 2'h1
`define FDCR_ST1_DATA_ERR 5
`define FDCR_ST2_CTRL_MARK 6
`define FDCR_ST3_READY_BIT 5
`define FDCR_FIRST_SECTOR 8'h01
`define FDCR_HEAD_ONE 8'h01

`endif

// ===== src/fdcr_fifo.v
`timescale 1ns/1ps
// ----------------------------------------
// sector data fifo, registered read side
// ----------------------------------------
module fdcr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output reg in_ready,
  output reg out_valid,
  output reg [WIDTH-1:0] out_data,
  input wire out_ready,
  output reg empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  wire push;
  wire pop;

  assign push = in_valid && in_ready;
  // output stage reloads whenever it is empty or being taken
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // occupancy of the storage array
  always @*
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // full is registered so the writer sees a clean ready
  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      empty <= 1'b1;
    end
    else
    begin
      count <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
        rd_ptr <= rd_ptr + 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      empty <= (next_count == {(AW+1){1'b0}}) &&
        !(pop || (out_valid && !out_ready));
    end
  end
endmodule

// ===== src/fdcr_step_timer.v
`timescale 1ns/1ps
// ----------------------------------------
// head step pulse spacing
// ----------------------------------------
module fdcr_step_timer #(
  parameter UNIT_CYCLES = 50000,
  parameter CW = 20
) (
  input wire clk,
  input wire rst,
  input wire req,
  input wire [3:0] interval,
  output reg pulse,
  output reg busy
);
  reg [CW-1:0] unit;
  reg [4:0] units_left;

  // interval code k spaces pulses by (k+1) half-millisecond units
  always @(posedge clk)
  begin
    if (rst)
    begin
      pulse <= 1'b0;
      busy <= 1'b0;
      unit <= {CW{1'b0}};
      units_left <= 5'h00;
    end
    else
    begin
      pulse <= 1'b0;
      if (!busy && req)
      begin
        pulse <= 1'b1;
        busy <= 1'b1;
        // first unit one short: the re-request costs a cycle, so pulse
        // to pulse is exactly (k+1) units; needs UNIT_CYCLES of 2 or more
        unit <= UNIT_CYCLES[CW-1:0] - 2'd2;
        units_left <= {1'b0, interval};
      end
      else if (busy)
      begin
        if (unit != {CW{1'b0}})
          unit <= unit - 1'b1;
        else if (units_left != 5'h00)
        begin
          units_left <= units_left - 1'b1;
          unit <= UNIT_CYCLES[CW-1:0] - 1'b1;
        end
        else
          busy <= 1'b0;
      end
    end
  end
endmodule

// ===== src/fdcr_read_cmd.v
`timescale 1ns/1ps
// Functional notes
// - precompensation start track takes any value 0 to 255.
// - sector byte names the sector read, first of a multi-sector run.
// - relative seek moves by an offset from the present cylinder.
// - per-track count sizes format, and verify when count enable set.
// - omit flag on plain read skips sectors with deleted mark.
// - omit flag on deleted read accesses only deleted-mark sectors.
// - omit flag clear reads every sector, none skipped.
// - step pulses spaced 0.5 to 8 ms in 0.5 ms steps.
// - four status bytes hold each command's outcome for the host.
// - pre-erase option changes write strobe timing.
// - nine command bytes: opcode, drive/head, then sector id and limits.
// - after command bytes, execution moves sector data drive to host.
// - result begins with status zero, one, two in order.
// - then cylinder, head, sector, size code of end position.
// - multi-track continues from last head-0 sector to head 1.
// - density flag one selects double, zero single density.
// - sector size 128 shl code; code zero uses data length byte.
`include "fdcr_defines.vh"
module fdcr_read_cmd #(
  parameter STEP_UNIT_CYCLES = `FDCR_STEP_UNIT_CYC,
  parameter FIFO_DEPTH = 8
) (
  input wire REF_CLK,
  input wire RST,
  input wire CMD_WR,
  input wire [7:0] CMD_DATA,
  output reg CMD_READY,
  input wire RES_RD,
  output reg [7:0] RES_DATA,
  output reg RES_VALID,
  output reg EXEC_ACTIVE,
  output reg DOUBLE_DENSITY_SEL,
  output reg HEAD_SELECT,
  output reg DRIVE_SELECT_HI,
  output reg DRIVE_SELECT_LO,
  input wire DRV_SEC_START,
  input wire DRV_SEC_DELETED,
  input wire DRV_BYTE_VALID,
  input wire [7:0] DRV_BYTE,
  input wire DRV_SEC_END,
  input wire DRV_ERROR,
  output wire DRV_READY,
  output wire [7:0] HOST_DATA,
  output wire HOST_DATA_VALID,
  input wire HOST_DATA_READY,
  input wire [7:0] PRECOMP_START_TRACK,
  output reg PRECOMP_ON,
  input wire SEEK_REL,
  input wire SEEK_OUTWARD,
  input wire [7:0] RELATIVE_CYL_OFFSET,
  input wire [3:0] STEP_INTERVAL,
  output wire STEP_PULSE,
  output reg STEP_DIR,
  input wire [7:0] PER_TRACK_COUNT,
  input wire VERIFY_COUNT_EN,
  output reg [7:0] FORMAT_COUNT,
  output reg [7:0] VERIFY_COUNT,
  input wire PRE_ERASE_TIMING,
  input wire WRITE_GATE_REQ,
  output reg WRITE_STROBE,
  input wire DRIVE_READY_IN,
  output reg [7:0] RESULT_STATUS_THREE
);
  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam S_IDLE = 2'b00;
  localparam S_CMD = 2'b01;
  localparam S_EXEC = 2'b10;
  localparam S_RES = 2'b11;

  reg [1:0] state;
  reg [3:0] cmd_idx;
  reg [2:0] res_idx;
  reg multi_track;
  reg omit_deleted_flag;
  reg want_deleted;
  reg [7:0] cyl;
  reg [7:0] head;
  reg [7:0] sector;
  reg [7:0] size_code;
  reg [7:0] final_sector_num;
  reg [7:0] gap_length;
  reg [7:0] data_length_limit;
  reg [7:0] result_status_zero;
  reg [7:0] result_status_one;
  reg [7:0] result_status_two;
  reg in_sector;
  reg accept_sec;
  reg mark_mismatch;
  reg exec_done;
  reg [15:0] byte_cnt;
  reg [7:0] cur_cyl;
  reg [7:0] steps_left;
  reg write_gate_d;
  wire [15:0] sec_len;
  wire fifo_push;
  wire fifo_empty;
  wire step_busy;
  wire [4:0] opcode;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte count of one sector; code zero falls back on the length byte
  function [15:0] sector_bytes;
    input [7:0] code;
    input [7:0] dlen;
    reg [7:0] c;
    begin
      c = (code > `FDCR_MAX_SIZE_CODE) ? `FDCR_MAX_SIZE_CODE : code;
      if (c == 8'h00)
        sector_bytes = {8'h00, dlen};
      else
        sector_bytes = `FDCR_BASE_LEN << c[2:0];
    end
  endfunction

  // decide whether a sector's mark lets it through
  function sector_taken;
    input omit;
    input want_del;
    input is_del;
    begin
      if (!omit)
        sector_taken = 1'b1;
      else
        sector_taken = (is_del == want_del);
    end
  endfunction

  assign sec_len = sector_bytes(size_code, data_length_limit);
  assign opcode = CMD_DATA[`FDCR_OP_MSB:0];
  // bytes past the sector length are dropped, not forwarded
  assign fifo_push = (state == S_EXEC) && in_sector && accept_sec &&
    DRV_BYTE_VALID && (byte_cnt < sec_len);

  // ----------------------------------------
  // sector data buffer towards the host
  // ----------------------------------------
  fdcr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(fifo_push),
    .in_data(DRV_BYTE),
    .in_ready(DRV_READY),
    .out_valid(HOST_DATA_VALID),
    .out_data(HOST_DATA),
    .out_ready(HOST_DATA_READY),
    .empty(fifo_empty)
  );

  // ----------------------------------------
  // head stepping
  // ----------------------------------------
  fdcr_step_timer #(
    .UNIT_CYCLES(STEP_UNIT_CYCLES),
    .CW(20)
  ) u_step (
    .clk(REF_CLK),
    .rst(RST),
    .req((steps_left != 8'h00) && !step_busy),
    .interval(STEP_INTERVAL),
    .pulse(STEP_PULSE),
    .busy(step_busy)
  );

  // relative seek: offset applied to the present cylinder
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      cur_cyl <= 8'h00;
      steps_left <= 8'h00;
      STEP_DIR <= 1'b0;
    end
    else if (SEEK_REL && steps_left == 8'h00 && state == S_IDLE)
    begin
      steps_left <= RELATIVE_CYL_OFFSET;
      STEP_DIR <= SEEK_OUTWARD;
      // outward heads towards track zero, inward away from it
      if (SEEK_OUTWARD)
        cur_cyl <= cur_cyl - RELATIVE_CYL_OFFSET;
      else
        cur_cyl <= cur_cyl + RELATIVE_CYL_OFFSET;
    end
    else if (steps_left != 8'h00 && !step_busy)
      steps_left <= steps_left - 1'b1;
  end

  // ----------------------------------------
  // side outputs: precomp, counts, write strobe
  // ----------------------------------------
  // full 8-bit compare, so every start track 0..255 works
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      PRECOMP_ON <= 1'b0;
      FORMAT_COUNT <= 8'h00;
      VERIFY_COUNT <= 8'h00;
      write_gate_d <= 1'b0;
      WRITE_STROBE <= 1'b0;
      RESULT_STATUS_THREE <= 8'h00;
    end
    else
    begin
      PRECOMP_ON <= (cur_cyl >= PRECOMP_START_TRACK);
      FORMAT_COUNT <= PER_TRACK_COUNT;
      VERIFY_COUNT <= VERIFY_COUNT_EN ? PER_TRACK_COUNT : 8'h00;
      write_gate_d <= WRITE_GATE_REQ;
      // pre-erase asserts the strobe a cycle earlier
      WRITE_STROBE <= PRE_ERASE_TIMING ? WRITE_GATE_REQ :
        write_gate_d;
      RESULT_STATUS_THREE <= {2'b00, DRIVE_READY_IN, 2'b00, HEAD_SELECT,
        DRIVE_SELECT_HI, DRIVE_SELECT_LO};
    end
  end

  // ----------------------------------------
  // command, execution and result sequencer
  // ----------------------------------------
  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= S_IDLE;
      cmd_idx <= 4'h0;
      res_idx <= 3'h0;
      CMD_READY <= 1'b1;
      RES_DATA <= 8'h00;
      RES_VALID <= 1'b0;
      EXEC_ACTIVE <= 1'b0;
      DOUBLE_DENSITY_SEL <= 1'b0;
      HEAD_SELECT <= 1'b0;
      DRIVE_SELECT_HI <= 1'b0;
      DRIVE_SELECT_LO <= 1'b0;
      multi_track <= 1'b0;
      omit_deleted_flag <= 1'b0;
      want_deleted <= 1'b0;
      cyl <= 8'h00;
      head <= 8'h00;
      sector <= 8'h00;
      size_code <= 8'h00;
      final_sector_num <= 8'h00;
      gap_length <= 8'h00;
      data_length_limit <= 8'h00;
      result_status_zero <= 8'h00;
      result_status_one <= 8'h00;
      result_status_two <= 8'h00;
      in_sector <= 1'b0;
      accept_sec <= 1'b0;
      mark_mismatch <= 1'b0;
      exec_done <= 1'b0;
      byte_cnt <= 16'h0000;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          // unknown opcodes are ignored and leave the block idle
          if (CMD_WR && (opcode == `FDCR_OP_READ ||
              opcode == `FDCR_OP_READ_DEL))
          begin
            multi_track <= CMD_DATA[`FDCR_MT_BIT];
            DOUBLE_DENSITY_SEL <= CMD_DATA[`FDCR_DD_BIT];
            omit_deleted_flag <= CMD_DATA[`FDCR_SK_BIT];
            want_deleted <= (opcode == `FDCR_OP_READ_DEL);
            cmd_idx <= 4'h1;
            state <= S_CMD;
          end
        end
        S_CMD:
        begin
          if (CMD_WR)
          begin
            case (cmd_idx)
              4'h1:
              begin
                HEAD_SELECT <= CMD_DATA[`FDCR_HEAD_BIT];
                DRIVE_SELECT_HI <= CMD_DATA[`FDCR_DS_HI_BIT];
                DRIVE_SELECT_LO <= CMD_DATA[`FDCR_DS_LO_BIT];
              end
              4'h2: cyl <= CMD_DATA;
              4'h3: head <= CMD_DATA;
              4'h4: sector <= CMD_DATA;
              4'h5: size_code <= CMD_DATA;
              4'h6: final_sector_num <= CMD_DATA;
              4'h7: gap_length <= CMD_DATA;
              default: data_length_limit <= CMD_DATA;
            endcase
            cmd_idx <= cmd_idx + 1'b1;
            if (cmd_idx == `FDCR_CMD_LAST)
            begin
              // only the ninth byte opens execution
              state <= S_EXEC;
              CMD_READY <= 1'b0;
              EXEC_ACTIVE <= 1'b1;
              exec_done <= 1'b0;
              in_sector <= 1'b0;
              mark_mismatch <= 1'b0;
              result_status_one <= 8'h00;
              result_status_two <= 8'h00;
            end
          end
        end
        S_EXEC:
        begin
          if (!exec_done && DRV_ERROR)
          begin
            result_status_one[`FDCR_ST1_DATA_ERR] <= 1'b1;
            exec_done <= 1'b1;
            in_sector <= 1'b0;
          end
          else if (!exec_done && DRV_SEC_START)
          begin
            in_sector <= 1'b1;
            byte_cnt <= 16'h0000;
            accept_sec <= sector_taken(omit_deleted_flag, want_deleted,
              DRV_SEC_DELETED);
            mark_mismatch <= (DRV_SEC_DELETED != want_deleted);
          end
          else if (in_sector && DRV_SEC_END)
          begin
            in_sector <= 1'b0;
            // a mark mismatch read through ends the run after that sector
            if (accept_sec && mark_mismatch)
            begin
              result_status_two[`FDCR_ST2_CTRL_MARK] <= 1'b1;
              exec_done <= 1'b1;
            end
            if (sector == final_sector_num)
            begin
              if (multi_track && head == 8'h00)
              begin
                head <= `FDCR_HEAD_ONE;
                HEAD_SELECT <= 1'b1;
                sector <= `FDCR_FIRST_SECTOR;
              end
              else
              begin
                cyl <= cyl + 1'b1;
                sector <= `FDCR_FIRST_SECTOR;
                exec_done <= 1'b1;
              end
            end
            else
              sector <= sector + 1'b1;
          end
          else if (fifo_push && DRV_READY)
            byte_cnt <= byte_cnt + 1'b1;
          // result waits until the host has drained every data byte
          if (exec_done && fifo_empty && !HOST_DATA_VALID)
          begin
            result_status_zero <= {(result_status_one != 8'h00) ?
              `FDCR_IC_ABNORMAL : `FDCR_IC_NORMAL, 3'b000, HEAD_SELECT,
              DRIVE_SELECT_HI, DRIVE_SELECT_LO};
            RES_DATA <= {(result_status_one != 8'h00) ?
              `FDCR_IC_ABNORMAL : `FDCR_IC_NORMAL, 3'b000, HEAD_SELECT,
              DRIVE_SELECT_HI, DRIVE_SELECT_LO};
            RES_VALID <= 1'b1;
            res_idx <= 3'h0;
            EXEC_ACTIVE <= 1'b0;
            state <= S_RES;
          end
        end
        S_RES:
        begin
          if (RES_RD)
          begin
            res_idx <= res_idx + 1'b1;
            case (res_idx)
              3'h0: RES_DATA <= result_status_one;
              3'h1: RES_DATA <= result_status_two;
              3'h2: RES_DATA <= cyl;
              3'h3: RES_DATA <= head;
              3'h4: RES_DATA <= sector;
              3'h5: RES_DATA <= size_code;
              default: RES_DATA <= 8'h00;
            endcase
            if (res_idx == `FDCR_RES_LAST)
            begin
              RES_VALID <= 1'b0;
              CMD_READY <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== verif/fdcr_read_cmd_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the read command block
// ----------------------------------------
module fdcr_read_cmd_assertions (
  input wire REF_CLK,
  input wire RST,
  input wire CMD_WR,
  input wire CMD_READY,
  input wire RES_RD,
  input wire [7:0] RES_DATA,
  input wire RES_VALID,
  input wire EXEC_ACTIVE,
  input wire STEP_PULSE,
  input wire [7:0] PER_TRACK_COUNT,
  input wire VERIFY_COUNT_EN,
  input wire [7:0] FORMAT_COUNT,
  input wire [7:0] VERIFY_COUNT
);
  // one clock domain, so one default clock and disable
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  property p_reset_idle;
    $fell(RST) |-> CMD_READY && !RES_VALID && !EXEC_ACTIVE;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("levels wrong after reset");

  property p_exec_start;
    $rose(EXEC_ACTIVE) |-> $past(CMD_WR) && $past(CMD_READY);
  endproperty
  a_exec_start: assert property (p_exec_start)
    else $error("execution began without a command byte");

  property p_exec_busy;
    EXEC_ACTIVE || RES_VALID |-> !CMD_READY;
  endproperty
  a_exec_busy: assert property (p_exec_busy)
    else $error("command side open while busy");

  property p_res_hold;
    RES_VALID && !RES_RD |=> RES_VALID && $stable(RES_DATA);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result byte moved without a read");

  property p_res_end;
    $fell(RES_VALID) |-> $past(RES_RD) && CMD_READY;
  endproperty
  a_res_end: assert property (p_res_end)
    else $error("result phase ended wrongly");

  // even the shortest interval leaves three quiet cycles
  property p_step_space;
    STEP_PULSE |=> !STEP_PULSE [*3];
  endproperty
  a_step_space: assert property (p_step_space)
    else $error("step pulses too close");

  property p_verify_off;
    !VERIFY_COUNT_EN && !$past(VERIFY_COUNT_EN) |-> VERIFY_COUNT == 8'h00;
  endproperty
  a_verify_off: assert property (p_verify_off)
    else $error("verify count set while disabled");

  property p_format_track;
    !$past(RST) |-> FORMAT_COUNT == $past(PER_TRACK_COUNT);
  endproperty
  a_format_track: assert property (p_format_track)
    else $error("format count does not follow input");
endmodule

bind fdcr_read_cmd fdcr_read_cmd_assertions u_chk (.*);

// ===== verif/fdcr_drive_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// drive side: sector stream source
// ----------------------------------------
module fdcr_drive_model (
  input wire clk,
  input wire rdy,
  output reg start,
  output reg del,
  output reg valid,
  output reg [7:0] data,
  output reg fin,
  output reg err
);
  // quiet stream at time zero
  initial
  begin
    {start, del, valid, fin, err} = 5'h00;
    data = 8'h00;
  end

  // mark, bytes held until taken, end; a quiet cycle between each
  task sector(input d, input integer n, input [7:0] b);
    integer k;
    begin
      @(negedge clk);
      start = 1;
      del = d;
      @(negedge clk);
      start = 0;
      del = ~d;
      for (k = 0; k < n; k = k + 1)
      begin
        @(negedge clk);
        valid = 1;
        data = 8'(b + k);
        while (!rdy) @(negedge clk);
        @(negedge clk);
        valid = 0;
        data = ~data; // stale byte must never look valid
      end
      @(negedge clk);
      fin = 1;
      @(negedge clk);
      fin = 0;
    end
  endtask

  // one-cycle data error from the drive
  task data_error;
    begin
      @(negedge clk);
      err = 1;
      @(negedge clk);
      err = 0;
    end
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench top: host driver and checks
// ----------------------------------------
module tb;
  localparam UNIT = 4;
  reg REF_CLK, RST, CMD_WR, RES_RD, HOST_DATA_READY, SEEK_REL, SEEK_OUTWARD;
  reg VERIFY_COUNT_EN, PRE_ERASE_TIMING, WRITE_GATE_REQ, DRIVE_READY_IN;
  reg [7:0] CMD_DATA, PRECOMP_START_TRACK, RELATIVE_CYL_OFFSET;
  reg [7:0] PER_TRACK_COUNT;
  reg [3:0] STEP_INTERVAL;
  wire CMD_READY, RES_VALID, EXEC_ACTIVE, DOUBLE_DENSITY_SEL, HEAD_SELECT;
  wire DRIVE_SELECT_HI, DRIVE_SELECT_LO, DRV_READY, HOST_DATA_VALID;
  wire PRECOMP_ON, STEP_PULSE, STEP_DIR, WRITE_STROBE, DRV_ERROR;
  wire DRV_SEC_START, DRV_SEC_DELETED, DRV_BYTE_VALID, DRV_SEC_END;
  wire [7:0] RES_DATA, HOST_DATA, DRV_BYTE, FORMAT_COUNT, VERIFY_COUNT;
  wire [7:0] RESULT_STATUS_THREE;
  integer failures, num_checks, i, t0, dt;
  reg host_take;
  reg [7:0] host_want;
  reg [55:0] re, rm;
  reg [7:0] exp_q[$];

  fdcr_read_cmd #(.STEP_UNIT_CYCLES(UNIT)) u_dut (.*);
  fdcr_drive_model u_drv (.clk(REF_CLK), .rdy(DRV_READY),
    .start(DRV_SEC_START), .del(DRV_SEC_DELETED), .valid(DRV_BYTE_VALID),
    .data(DRV_BYTE), .fin(DRV_SEC_END), .err(DRV_ERROR));

  // 100 mhz clock
  initial
  begin
    REF_CLK = 0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task check(input [7:0] got, input [7:0] want);
    begin
      num_checks = num_checks + 1;
      if (got !== want)
      begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // host drains the stream with random stalls, so the fifo fills;
  // the byte is checked with the ready that the next edge will see
  always @(negedge REF_CLK)
  begin
    host_take = ($urandom % 3) == 0;
    if (HOST_DATA_VALID === 1'b1 && host_take)
    begin
      host_want = exp_q.size() ? exp_q.pop_front() : ~HOST_DATA;
      check(HOST_DATA, host_want);
    end
    HOST_DATA_READY <= host_take;
  end

  task put(input [7:0] b);
    begin
      @(negedge REF_CLK);
      CMD_WR = 1;
      CMD_DATA = b;
    end
  endtask

  // nine bytes back to back, first byte in the top field
  task command(input [71:0] v);
    begin
      for (i = 8; i >= 0; i = i - 1)
        put(v[i * 8 +: 8]);
      @(negedge REF_CLK);
      CMD_WR = 0;
      check(EXEC_ACTIVE, 1);
      check(CMD_READY, 0);
      check({DOUBLE_DENSITY_SEL, HEAD_SELECT, DRIVE_SELECT_HI,
        DRIVE_SELECT_LO}, {v[70], v[58:56]});
    end
  endtask

  // one sector; only the first take bytes may reach the host
  task sec(input d, input integer n, input integer take);
    reg [7:0] b;
    integer k;
    begin
      b = $urandom;
      for (k = 0; k < take; k = k + 1)
        exp_q.push_back(8'(b + k));
      u_drv.sector(d, n, b);
    end
  endtask

  // seven result bytes under mask rm against re
  task results;
    integer k;
    begin
      k = 0;
      while (RES_VALID !== 1'b1 && k < 5000)
      begin
        @(negedge REF_CLK);
        k = k + 1;
      end
      for (k = 0; k < 7; k = k + 1)
      begin
        check(RES_DATA & rm[(6 - k) * 8 +: 8],
          re[(6 - k) * 8 +: 8]);
        RES_RD = 1;
        @(negedge REF_CLK);
        RES_RD = 0;
        @(negedge REF_CLK);
      end
      check(CMD_READY, 1);
      check(exp_q.size() == 0, 1);
    end
  endtask

  task wait_pulse;
    integer w;
    begin
      w = 0;
      @(negedge REF_CLK);
      while (STEP_PULSE !== 1'b1 && w < 200)
      begin
        @(negedge REF_CLK);
        w = w + 1;
      end
    end
  endtask

  // cycles beyond the first from gate request to strobe
  task gate_lat(input pre, output integer n);
    begin
      PRE_ERASE_TIMING = pre;
      WRITE_GATE_REQ = 1;
      n = 0;
      @(negedge REF_CLK);
      while (WRITE_STROBE !== 1'b1 && n < 8)
      begin
        @(negedge REF_CLK);
        n = n + 1;
      end
      WRITE_GATE_REQ = 0;
      repeat (4) @(negedge REF_CLK);
    end
  endtask

  // watchdog, well beyond the expected run
  initial
  begin
    #300000;
    failures = failures + 1;
    report_and_stop;
  end

  initial
  begin
    i = $urandom(32'h859d);
    failures = 0;
    num_checks = 0;
    {RST, CMD_WR, RES_RD, HOST_DATA_READY, SEEK_REL, SEEK_OUTWARD} = 6'h20;
    {VERIFY_COUNT_EN, PRE_ERASE_TIMING, WRITE_GATE_REQ, DRIVE_READY_IN} = 4'h0;
    CMD_DATA = 8'h00;
    PRECOMP_START_TRACK = 8'h00;
    RELATIVE_CYL_OFFSET = 8'h05;
    PER_TRACK_COUNT = 8'h00;
    STEP_INTERVAL = $urandom;
    repeat (4) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST = 0;
    // seek inward by five, spacing of the step pulses
    SEEK_REL = 1;
    @(negedge REF_CLK);
    SEEK_REL = 0;
    wait_pulse;
    t0 = $time;
    wait_pulse;
    dt = ($time - t0) / 10;
    check(dt[7:0], 8'((STEP_INTERVAL + 1) * UNIT));
    check(STEP_DIR, 8'h00);
    repeat (400) @(negedge REF_CLK);
    // start tracks 0, 5, 6, ff against cylinder five
    for (i = 0; i < 4; i = i + 1)
    begin
      PRECOMP_START_TRACK = 8'(32'h0005_06FF >> (24 - 8 * i));
      repeat (2) @(negedge REF_CLK);
      check(PRECOMP_ON, i < 2);
    end
    PER_TRACK_COUNT = $urandom;
    VERIFY_COUNT_EN = 1;
    DRIVE_READY_IN = 1;
    repeat (2) @(negedge REF_CLK);
    check(FORMAT_COUNT, PER_TRACK_COUNT);
    check(VERIFY_COUNT, PER_TRACK_COUNT);
    check(RESULT_STATUS_THREE, 8'h20);
    VERIFY_COUNT_EN = 0;
    gate_lat(1, t0);
    gate_lat(0, dt);
    check(dt[7:0], t0[7:0] + 8'h01);
    check(t0[7:0], 8'h00);
    check(VERIFY_COUNT, 8'h00);
    $display("test of seek and options done");
    // unknown opcode is ignored
    put(8'h05);
    @(negedge REF_CLK);
    CMD_WR = 0;
    repeat (3) @(negedge REF_CLK);
    check(EXEC_ACTIVE, 0);
    check(CMD_READY, 1);
    $display("test of refused opcode done");
    // one sector of code one, the drive overruns its length
    re = 56'h00_0000_0800_0101;
    rm = 56'hC0_FFFF_FFFF_FFFF;
    command(72'h46_0107_0001_0101_1BFF);
    sec(0, 258, 256);
    results;
    $display("test of long sector done");
    // multi-track with skip: deleted sector passed over
    re = 56'h00_0000_0301_0100;
    command(72'hA6_0002_0001_0002_1B03);
    sec(0, 5, 3);
    sec(1, 5, 0);
    sec(0, 5, 3);
    sec(0, 5, 3);
    results;
    $display("test of multi-track skip done");
    // deleted read with skip takes only deleted sectors
    re = 56'h00_0000_0501_0100;
    command(72'h6C_0604_0101_0002_1B02);
    sec(0, 4, 0);
    sec(1, 4, 4 - 2);
    results;
    $display("test of deleted read done");
    // no skip: deleted sector is read and flagged
    re = 56'h00_0040_0000_0000;
    rm = 56'h00_0040_0000_00FF;
    command(72'h06_0309_0001_0003_1B04);
    sec(1, 4, 4);
    results;
    $display("test of mark mismatch done");
    // drive error: abnormal end, sector id left where it was
    re = 56'h41_2000_0A00_0100;
    rm = 56'hFF_FFFF_FFFF_FFFF;
    command(72'h46_010A_0001_0001_1B10);
    u_drv.data_error;
    results;
    $display("test of drive error done");
    report_and_stop;
  end
endmodule
